// [core/bfdma_pkg.sv]
// constants and carrier types for the board feature / dma control block
// assumes one system clock; used by bfdma_ctrl, bfdma_chk and tb
package bfdma_pkg;
  // byte offsets, port a / port b
  localparam logic [7:0] BFDMA_FEAT_A = 8'h00;
  localparam logic [7:0] BFDMA_CMD_A = 8'h04;
  localparam logic [7:0] BFDMA_CMD_B = 8'h08;
  localparam logic [7:0] BFDMA_RXB_A = 8'h0c;
  localparam logic [7:0] BFDMA_TXB_A = 8'h10;
  localparam logic [7:0] BFDMA_RXB_B = 8'h14;
  localparam logic [7:0] BFDMA_TXB_B = 8'h18;
  localparam logic [7:0] BFDMA_FEAT_B = 8'h1c;
  localparam logic [7:0] BFDMA_CRX_A = 8'h20;
  localparam logic [7:0] BFDMA_CTX_A = 8'h24;
  localparam logic [7:0] BFDMA_CRX_B = 8'h28;
  localparam logic [7:0] BFDMA_CTX_B = 8'h2c;
  localparam logic [7:0] BFDMA_STAT = 8'h30;
  // feature control fields, port a; port b adds BFDMA_F_PORT_OFS (synth), BFDMA_F_MODE_OFS (mode) or 1 (uart)
  localparam int BFDMA_F_DATA = 0;
  localparam int BFDMA_F_SCLK = 1;
  localparam int BFDMA_F_LATCH = 3;
  localparam int BFDMA_F_PORT_OFS = 8;
  localparam int BFDMA_F_ECHO = 16;
  localparam int BFDMA_F_TCLK = 17;
  localparam int BFDMA_F_TDAT = 18;
  localparam int BFDMA_F_MODE_OFS = 4;
  localparam int BFDMA_F_UART = 24;
  // writable feature bits; 26..31 reserved, kept zero
  localparam logic [31:0] BFDMA_FEAT_MASK = 32'h0377_0b0b;
  localparam logic [31:0] BFDMA_FEAT_RST = 32'h0000_0000;
  // command bits
  localparam int BFDMA_C_GO_RX = 0;
  localparam int BFDMA_C_GO_TX = 1;
  localparam int BFDMA_C_RST_RX = 4;
  localparam int BFDMA_C_RST_TX = 5;
  localparam int BFDMA_C_STOP_RX = 8;
  localparam int BFDMA_C_STOP_TX = 9;
  localparam int BFDMA_C_MRST = 16;
  localparam logic [31:0] BFDMA_ADDR_RST = 32'h0000_0000;
  localparam logic [4:0] BFDMA_STAT_RST = 5'h0f;
  localparam logic [1:0] BFDMA_RESP_OKAY = 2'b00;
  localparam logic [1:0] BFDMA_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {BFDMA_IDLE, BFDMA_FETCH, BFDMA_RUN} bfdma_dir_e;

  // per-port line controls toward the serial front end
  typedef struct packed {
    logic synth_prog_data;
    logic synth_prog_sclk;
    logic synth_prog_latch;
    logic rx_blank_on_tx;
    logic txclk_tristate_idle;
    logic txdata_tristate_idle;
    logic uart_select;
  } bfdma_lines_s;

  // per-direction request toward the descriptor engine
  typedef struct packed {
    logic fetch;
    logic [31:0] addr;
    logic flush;
    logic halt_irq;
  } bfdma_dreq_s;

  // per-direction report from the descriptor engine
  typedef struct packed {
    logic busy;
    logic done;
    logic desc_valid;
    logic [31:0] desc_addr;
  } bfdma_drep_s;
endpackage

// [core/bfdma_ctrl.sv]
// board feature, dma command and dma status registers for two serial ports
// assumes an axi4-lite master on clock and a descriptor engine that reports
// fetched descriptors, chain end and fatal bus faults on the same clock
//
// Overview of operation
// - feature bits drive port a synth lines
// - feature bits drive port b synth lines
// - echo cancel blanks receiver while transmitting
// - tx clock driver tristates when idle
// - tx data driver tristates when idle
// - connection select routes uart or sync
// - command bits act on one, self-clear
// - go rx fetches receive base descriptor
// - go tx fetches transmit base descriptor
// - rx reset flushes, returns to idle
// - tx reset flushes, returns to idle
// - rx stop halts and raises irq
// - tx stop halts and raises irq
// - master reset only in port a
// - enable bits 24, 25 do nothing
// - rx descriptor base registers per port
// - tx descriptor base registers per port
// - current descriptor address read-only registers
// - status bits report stopped and dead
// - master dead holds until master reset
`timescale 1ns/100ps
module bfdma_ctrl (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] tx_active,
  output bfdma_pkg::bfdma_lines_s [1:0] port_lines,
  output logic [1:0] rx_enable,
  output logic [1:0] txclk_drive_en,
  output logic [1:0] txdata_drive_en,
  // index: 0 rx a, 1 tx a, 2 rx b, 3 tx b
  output bfdma_pkg::bfdma_dreq_s [3:0] dma_req,
  input wire bfdma_pkg::bfdma_drep_s [3:0] dma_rep,
  input wire logic bus_fault,
  output logic master_reset
);
  import bfdma_pkg::*;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_rdy_reg, w_rdy_reg, ar_rdy_reg;
  wire aw_take = s_axi_awvalid && aw_rdy_reg;
  wire w_take = s_axi_wvalid && w_rdy_reg;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire ar_take = s_axi_arvalid && ar_rdy_reg;
  wire bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
  wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
  wire [7:0] wa = aw_addr_reg;
  wire [7:0] ra = s_axi_araddr;
  // full-word byte merge for partial strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] feat_reg [2];
  logic [31:0] rx_base_reg [2];
  logic [31:0] tx_base_reg [2];
  logic [31:0] cur_reg [4];
  bfdma_dir_e dir_reg [4];
  logic [3:0] halted_reg;
  logic dead_reg;
  bfdma_dreq_s [3:0] req_reg;
  logic mrst_reg;
  bfdma_lines_s [1:0] lines_reg;
  logic [1:0] rxen_reg;
  logic [1:0] tcen_reg;
  logic [1:0] tden_reg;
  wire wr_feat_a = do_write && (wa == BFDMA_FEAT_A);
  wire wr_feat_b = do_write && (wa == BFDMA_FEAT_B);
  wire wr_cmd_a = do_write && (wa == BFDMA_CMD_A);
  wire wr_cmd_b = do_write && (wa == BFDMA_CMD_B);
  wire wr_rxb_a = do_write && (wa == BFDMA_RXB_A);
  wire wr_txb_a = do_write && (wa == BFDMA_TXB_A);
  wire wr_rxb_b = do_write && (wa == BFDMA_RXB_B);
  wire wr_txb_b = do_write && (wa == BFDMA_TXB_B);
  wire wr_ro = do_write && ((wa == BFDMA_CRX_A) || (wa == BFDMA_CTX_A) || (wa == BFDMA_CRX_B) ||
    (wa == BFDMA_CTX_B) || (wa == BFDMA_STAT));
  wire wr_hit = wr_feat_a || wr_feat_b || wr_cmd_a || wr_cmd_b || wr_rxb_a || wr_txb_a || wr_rxb_b ||
    wr_txb_b || wr_ro;
  wire [31:0] wcmd = w_data_reg & {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
    {8{w_strb_reg[0]}}};
  wire [1:0] cmd_hit = {wr_cmd_b, wr_cmd_a};
  // master reset only from port a
  wire mrst_cmd = wr_cmd_a && wcmd[BFDMA_C_MRST];
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {27'h0, dead_reg, halted_reg};
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    if (ra == BFDMA_FEAT_A) begin
      rd_word = feat_reg[0];
    end else if (ra == BFDMA_FEAT_B) begin
      rd_word = feat_reg[1];
    end else if ((ra == BFDMA_CMD_A) || (ra == BFDMA_CMD_B)) begin
      rd_word = 32'h0000_0000;
    end else if (ra == BFDMA_RXB_A) begin
      rd_word = rx_base_reg[0];
    end else if (ra == BFDMA_TXB_A) begin
      rd_word = tx_base_reg[0];
    end else if (ra == BFDMA_RXB_B) begin
      rd_word = rx_base_reg[1];
    end else if (ra == BFDMA_TXB_B) begin
      rd_word = tx_base_reg[1];
    end else if (ra == BFDMA_CRX_A) begin
      rd_word = cur_reg[0];
    end else if (ra == BFDMA_CTX_A) begin
      rd_word = cur_reg[1];
    end else if (ra == BFDMA_CRX_B) begin
      rd_word = cur_reg[2];
    end else if (ra == BFDMA_CTX_B) begin
      rd_word = cur_reg[3];
    end else if (ra == BFDMA_STAT) begin
      rd_word = stat_word;
    end else begin
      rd_ok = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= BFDMA_RESP_OKAY;
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
    end else if (clk_en) begin
      aw_rdy_reg <= !bvalid_next && !aw_held_reg && !aw_take;
      w_rdy_reg <= !bvalid_next && !w_held_reg && !w_take;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? BFDMA_RESP_OKAY : BFDMA_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= BFDMA_RESP_OKAY;
      ar_rdy_reg <= 1'b1;
    end else if (clk_en) begin
      ar_rdy_reg <= !rvalid_next;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_ok ? BFDMA_RESP_OKAY : BFDMA_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // per-port feature, base address and line control
  // ----------------------------------------------------------------
  wire [1:0] feat_wr = {wr_feat_b, wr_feat_a};
  wire [1:0] rxb_wr = {wr_rxb_b, wr_rxb_a};
  wire [1:0] txb_wr = {wr_txb_b, wr_txb_a};
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int DO = p * BFDMA_F_PORT_OFS;
    localparam int MO = p * BFDMA_F_MODE_OFS;
    wire [31:0] fw = feat_reg[p];
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        feat_reg[p] <= BFDMA_FEAT_RST;
        rx_base_reg[p] <= BFDMA_ADDR_RST;
        tx_base_reg[p] <= BFDMA_ADDR_RST;
        lines_reg[p] <= '0;
        rxen_reg[p] <= 1'b1;
        tcen_reg[p] <= 1'b1;
        tden_reg[p] <= 1'b1;
      end else if (clk_en) begin
        if (feat_wr[p]) begin
          feat_reg[p] <= merge(feat_reg[p], w_data_reg, w_strb_reg) & BFDMA_FEAT_MASK;
        end
        if (rxb_wr[p]) begin
          rx_base_reg[p] <= merge(rx_base_reg[p], w_data_reg, w_strb_reg);
        end
        if (txb_wr[p]) begin
          tx_base_reg[p] <= merge(tx_base_reg[p], w_data_reg, w_strb_reg);
        end
        lines_reg[p].synth_prog_data <= fw[BFDMA_F_DATA + DO];
        lines_reg[p].synth_prog_sclk <= fw[BFDMA_F_SCLK + DO];
        lines_reg[p].synth_prog_latch <= fw[BFDMA_F_LATCH + DO];
        lines_reg[p].rx_blank_on_tx <= fw[BFDMA_F_ECHO + MO];
        lines_reg[p].txclk_tristate_idle <= fw[BFDMA_F_TCLK + MO];
        lines_reg[p].txdata_tristate_idle <= fw[BFDMA_F_TDAT + MO];
        lines_reg[p].uart_select <= fw[BFDMA_F_UART + p];
        rxen_reg[p] <= !(fw[BFDMA_F_ECHO + MO] && tx_active[p]);
        tcen_reg[p] <= !fw[BFDMA_F_TCLK + MO] || tx_active[p];
        tden_reg[p] <= !fw[BFDMA_F_TDAT + MO] || tx_active[p];
      end
    end
  end
  // ----------------------------------------------------------------
  // per-direction dma command sequencing
  // ----------------------------------------------------------------
  for (genvar d = 0; d < 4; d++) begin : g_dir
    localparam int P = d / 2;
    localparam bit IS_TX = (d % 2) == 1;
    localparam int GO = IS_TX ? BFDMA_C_GO_TX : BFDMA_C_GO_RX;
    localparam int RS = IS_TX ? BFDMA_C_RST_TX : BFDMA_C_RST_RX;
    localparam int SP = IS_TX ? BFDMA_C_STOP_TX : BFDMA_C_STOP_RX;
    wire c_go = cmd_hit[P] && wcmd[GO];
    wire c_rst = cmd_hit[P] && wcmd[RS];
    wire c_stop = cmd_hit[P] && wcmd[SP];
    wire [31:0] base = IS_TX ? tx_base_reg[P] : rx_base_reg[P];
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        dir_reg[d] <= BFDMA_IDLE;
        halted_reg[d] <= BFDMA_STAT_RST[d];
        cur_reg[d] <= BFDMA_ADDR_RST;
        req_reg[d] <= '0;
      end else if (clk_en) begin
        req_reg[d].fetch <= 1'b0;
        req_reg[d].flush <= 1'b0;
        req_reg[d].halt_irq <= 1'b0;
        if (dma_rep[d].desc_valid) begin
          cur_reg[d] <= dma_rep[d].desc_addr;
        end
        // idle; flush on reset or master reset, not on a dead master
        // reset, master reset and a dead master win over go
        if (c_rst || mrst_cmd || dead_reg) begin
          dir_reg[d] <= BFDMA_IDLE;
          halted_reg[d] <= 1'b1;
          req_reg[d].flush <= c_rst || mrst_cmd;
        end else if (c_stop) begin
          dir_reg[d] <= BFDMA_IDLE;
          halted_reg[d] <= 1'b1;
          req_reg[d].halt_irq <= 1'b1;
        end else if (c_go) begin
          dir_reg[d] <= BFDMA_FETCH;
          halted_reg[d] <= 1'b0;
          req_reg[d].fetch <= 1'b1;
          req_reg[d].addr <= base;
          cur_reg[d] <= base;
        end else begin
          case (dir_reg[d])
            BFDMA_FETCH: begin
              if (dma_rep[d].busy) begin
                dir_reg[d] <= BFDMA_RUN;
              end
            end
            BFDMA_RUN: begin
              if (dma_rep[d].done) begin
                dir_reg[d] <= BFDMA_IDLE;
                halted_reg[d] <= 1'b1;
              end
            end
            default: begin
              dir_reg[d] <= BFDMA_IDLE;
            end
          endcase
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // master engine status
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dead_reg <= 1'b0;
      mrst_reg <= 1'b0;
    end else if (clk_en) begin
      mrst_reg <= mrst_cmd;
      // dead sticks; fault wins over reset
      if (bus_fault) begin
        dead_reg <= 1'b1;
      end else if (mrst_cmd) begin
        dead_reg <= 1'b0;
      end
    end
  end
  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready = w_rdy_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign port_lines = lines_reg;
  assign rx_enable = rxen_reg;
  assign txclk_drive_en = tcen_reg;
  assign txdata_drive_en = tden_reg;
  assign dma_req = req_reg;
  assign master_reset = mrst_reg;
endmodule

// [dv/bfdma_chk.sv]
// assertions on the bus, line control and dma request ports of bfdma_ctrl
// assumes one clock domain; bound to every bfdma_ctrl instance
`timescale 1ns/100ps
module bfdma_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] tx_active,
  input wire bfdma_pkg::bfdma_lines_s [1:0] port_lines,
  input wire logic [1:0] rx_enable,
  input wire logic [1:0] txclk_drive_en,
  input wire logic [1:0] txdata_drive_en,
  input wire bfdma_pkg::bfdma_dreq_s [3:0] dma_req,
  input wire logic master_reset
);
  import bfdma_pkg::*;
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before rready");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before bready");
  a_rd_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3c
    |=> s_axi_rresp == BFDMA_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rx_blank: assert property ($past(clk_en) |->
    rx_enable[1] == !(port_lines[1].rx_blank_on_tx && $past(tx_active[1])))
    else $error("receiver enable wrong");
  a_clk_drive: assert property ($past(clk_en) |->
    txclk_drive_en[0] == (!port_lines[0].txclk_tristate_idle || $past(tx_active[0])))
    else $error("tx clock driver enable wrong");
  a_dat_drive: assert property ($past(clk_en) |->
    txdata_drive_en[1] == (!port_lines[1].txdata_tristate_idle || $past(tx_active[1])))
    else $error("tx data driver enable wrong");
  a_mrst_pulse: assert property (master_reset |=> !master_reset)
    else $error("master reset not a pulse");
  a_fetch_pulse: assert property (dma_req[0].fetch |=> !dma_req[0].fetch)
    else $error("fetch request not a pulse");

  c_mrst: cover property (master_reset);
  c_fetch: cover property (dma_req[3].fetch);
  c_halt: cover property (dma_req[0].halt_irq);
endmodule

bind bfdma_ctrl bfdma_chk u_chk (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_active(tx_active), .port_lines(port_lines), .rx_enable(rx_enable),
  .txclk_drive_en(txclk_drive_en), .txdata_drive_en(txdata_drive_en), .dma_req(dma_req),
  .master_reset(master_reset));

// [dv/tb.sv]
// self-checking bench for bfdma_ctrl, driven as an axi4-lite master
// assumes the descriptor engine side is driven here; clk_en stays high
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  import bfdma_pkg::*;
  logic clock, arst_n, clk_en, bus_fault, master_reset;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, tx_active, rx_enable, tce, tde;
  bfdma_lines_s [1:0] lines;
  bfdma_dreq_s [3:0] req;
  bfdma_drep_s [3:0] rep;
  int bad_count, n_checks, mrs;
  int fet[4], flu[4], hlt[4];
  logic [31:0] fadr[4];
  logic [7:0] ba[4] = '{BFDMA_RXB_A, BFDMA_TXB_A, BFDMA_RXB_B, BFDMA_TXB_B};
  logic [7:0] ca[4] = '{BFDMA_CRX_A, BFDMA_CTX_A, BFDMA_CRX_B, BFDMA_CTX_B};
  int pa[7] = '{0, 1, 3, 16, 17, 18, 24};
  int pb[7] = '{8, 9, 11, 20, 21, 22, 25};

  bfdma_ctrl DUT (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_active(tx_active), .port_lines(lines), .rx_enable(rx_enable), .txclk_drive_en(tce),
    .txdata_drive_en(tde), .dma_req(req), .dma_rep(rep), .bus_fault(bus_fault), .master_reset(master_reset));

  // ---------------------------------------------
  // clock, pulse counters, bus tasks
  // ---------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // sampled mid-cycle so registered pulses are seen exactly once
  always @(negedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (req[i].fetch === 1'b1) fadr[i] = req[i].addr;
      if (req[i].fetch === 1'b1) fet[i]++;
      if (req[i].flush === 1'b1) flu[i]++;
      if (req[i].halt_irq === 1'b1) hlt[i]++;
    end
    if (master_reset === 1'b1) mrs++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (ta) da = 1'b1;
      if (tw) wvalid <= 1'b0;
      if (tw) dw = 1'b1;
    end
    do @(negedge clock); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clock);
    bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic [1:0] r;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock); while (!(arvalid && arready));
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clock);
    rready <= 1'b0;
    `CHK("rresp", er, r)
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, BFDMA_RESP_OKAY, d);
    `CHK("read data", e, d)
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    rc(BFDMA_FEAT_A, 32'h0);
    rc(BFDMA_FEAT_B, 32'h0);
    rc(BFDMA_RXB_A, 32'h0);
    rc(BFDMA_TXB_B, 32'h0);
    rc(BFDMA_STAT, 32'h0f);
    `CHK("lines", 14'h0, lines)
    `CHK("rx_enable", 2'b11, rx_enable)
  endtask

  task automatic t_feature;
    logic [7:0] a;
    logic [31:0] v;
    for (int p = 0; p < 2; p++) begin
      a = p ? BFDMA_FEAT_B : BFDMA_FEAT_A;
      // reserved bits 26..31 always written zero
      v = (32'h0b << (8 * p)) | (32'h7 << (16 + 4 * p)) | (32'h1 << (24 + p));
      wr(a, v, BFDMA_RESP_OKAY);
      rc(a, v);
      @(negedge clock);
      `CHK("lines all", 7'h7f, lines[p])
      `CHK("lines other", 7'h00, lines[1 - p])
      // walk one field at a time so a swapped bit shows up
      for (int k = 0; k < 7; k++) begin
        wr(a, 32'h1 << (p ? pb[k] : pa[k]), BFDMA_RESP_OKAY);
        @(negedge clock);
        `CHK("line field", 7'h40 >> k, lines[p])
      end
      wr(a, 32'h0, BFDMA_RESP_OKAY);
    end
  endtask

  task automatic t_echo;
    logic [1:0] m;
    for (int p = 0; p < 2; p++) begin
      m = ~(2'b01 << p);
      wr(p ? BFDMA_FEAT_B : BFDMA_FEAT_A, 32'h7 << (16 + 4 * p), BFDMA_RESP_OKAY);
      for (int t = 0; t < 2; t++) begin
        @(posedge clock);
        tx_active <= t ? (2'b01 << p) : 2'b00;
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK("rx_enable", t ? m : 2'b11, rx_enable)
        `CHK("txclk_drive_en", t ? 2'b11 : m, tce)
        `CHK("txdata_drive_en", t ? 2'b11 : m, tde)
      end
      @(posedge clock);
      tx_active <= 2'b00;
      wr(p ? BFDMA_FEAT_B : BFDMA_FEAT_A, 32'h0, BFDMA_RESP_OKAY);
    end
  endtask

  task automatic t_dma;
    logic [7:0] c;
    for (int i = 0; i < 4; i++) begin
      wr(ba[i], 32'h1000_0010 * (i + 1), BFDMA_RESP_OKAY);
      rc(ba[i], 32'h1000_0010 * (i + 1));
    end
    wstrb <= 4'h1;
    wr(BFDMA_RXB_A, 32'haaaa_aaaa, BFDMA_RESP_OKAY);
    wstrb <= 4'hf;
    rc(BFDMA_RXB_A, 32'h1000_00aa);
    wr(BFDMA_RXB_A, 32'h1000_0010, BFDMA_RESP_OKAY);
    wr(BFDMA_CRX_A, 32'hffff_ffff, BFDMA_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      c = i < 2 ? BFDMA_CMD_A : BFDMA_CMD_B;
      wr(c, 32'h1 << (i % 2), BFDMA_RESP_OKAY);
      repeat (3) @(posedge clock);
      `CHK("fetch count", 1, fet[i])
      `CHK("fetch addr", 32'h1000_0010 * (i + 1), fadr[i])
      rc(BFDMA_STAT, 32'h0f ^ (32'h1 << i));
      rc(c, 32'h0);
      rep[i].desc_addr <= 32'hd000_0000 + i;
      rep[i].desc_valid <= 1'b1;
      @(posedge clock);
      rep[i].desc_valid <= 1'b0;
      rc(ca[i], 32'hd000_0000 + i);
      wr(c, 32'h1 << (8 + i % 2), BFDMA_RESP_OKAY);
      repeat (3) @(posedge clock);
      `CHK("halt irq", 1, hlt[i])
      rc(BFDMA_STAT, 32'h0f);
      // dma reset only with serial side idle
      wr(c, 32'h1 << (4 + i % 2), BFDMA_RESP_OKAY);
      repeat (3) @(posedge clock);
      `CHK("flush", 1, flu[i])
    end
    wr(BFDMA_CMD_A, 32'h0300_0000, BFDMA_RESP_OKAY);
    repeat (3) @(posedge clock);
    `CHK("enable bits", 2, fet[0] + fet[1])
    rc(BFDMA_STAT, 32'h0f);
    // engine busy then done: the run ends with the direction stopped
    wr(BFDMA_CMD_A, 32'h1, BFDMA_RESP_OKAY);
    rep[0].busy <= 1'b1;
    @(posedge clock);
    rep[0].busy <= 1'b0;
    rc(BFDMA_STAT, 32'h0e);
    rep[0].done <= 1'b1;
    @(posedge clock);
    rep[0].done <= 1'b0;
    rc(BFDMA_STAT, 32'h0f);
  endtask

  task automatic t_dead;
    logic [31:0] d;
    @(posedge clock);
    bus_fault <= 1'b1;
    @(posedge clock);
    bus_fault <= 1'b0;
    rc(BFDMA_STAT, 32'h1f);
    wr(BFDMA_CMD_B, 32'h0001_0000, BFDMA_RESP_OKAY);
    rc(BFDMA_STAT, 32'h1f);
    `CHK("master reset b", 0, mrs)
    wr(BFDMA_CMD_A, 32'h0001_0000, BFDMA_RESP_OKAY);
    repeat (3) @(posedge clock);
    `CHK("master reset a", 1, mrs)
    rc(BFDMA_STAT, 32'h0f);
    rd(8'h3c, BFDMA_RESP_SLVERR, d);
    `CHK("unmapped data", 32'h0, d)
    wr(8'h3c, 32'h1, BFDMA_RESP_SLVERR);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, bus_fault} = '0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    tx_active = 2'b00;
    rep = '0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_feature();
    t_echo();
    t_dma();
    t_dead();
    summarize();
  end
endmodule
